// [rtl/audio_clock_generation.sv]
// audio clock generation: divider, fractional loop model and aux clock output
`timescale 1ns/10ps
`default_nettype none
module audio_clock_generation (
   input  wire logic        i_ref_clk,
   input  wire logic        i_arst_n,
   input  wire logic        i_mclk,
   input  wire logic        i_bclk,
   input  wire logic        i_aux_pin_two,
   input  wire logic        i_src_sel_wr,
   input  wire logic [7:0]  i_src_sel_data,
   input  wire logic        i_clk_path_en,
   input  wire logic        i_converter_pwr,
   input  wire logic        i_pll_en,
   input  wire logic        i_clockout_source_select,
   input  wire logic [4:0]  i_q,
   input  wire logic [3:0]  i_p,
   input  wire logic [4:0]  i_r,
   input  wire logic [5:0]  i_j,
   input  wire logic [13:0] i_d,
   input  wire logic [3:0]  i_m,
   input  wire logic [4:0]  i_n,
   input  wire logic [3:0]  i_dac_rate_ratio,
   input  wire logic        i_double_rate,
   output logic [7:0]       o_clock_source_select,
   output logic             o_master_tick,
   output logic             o_fsref_tick,
   output logic             o_dac_sample_tick,
   output logic             o_aux_pin_one,
   output logic             o_cfg_error
);
   localparam int W = audio_clock_pkg::ACC_W;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // one accumulator step; the top bit of the result is the output pulse.
   // pulses are limited to one per reference cycle, the surplus stays as
   // credit until the accumulator saturates at all ones, so a faster source is rate limited and surplus past that is lost
   function automatic logic [W:0] nco_step(input logic [W-1:0] acc,
                                           input logic [W-1:0] inc,
                                           input logic [W-1:0] thr,
                                           input logic         edge_in);
      logic [W:0] sum;
      logic [W:0] rest;
      sum  = {1'b0, acc} + (edge_in ? {1'b0, inc} : {(W+1){1'b0}});
      rest = (sum >= {1'b0, thr}) ? sum - {1'b0, thr} : sum;
      if (rest[W])
         rest = {1'b0, {W{1'b1}}};
      return {(sum >= {1'b0, thr}), rest[W-1:0]};
   endfunction : nco_step

   function automatic logic pick_edge(input logic [1:0] sel,
                                      input logic [2:0] edges);
      unique case (sel)
         audio_clock_pkg::SRC_MCLK : pick_edge = edges[0];
         audio_clock_pkg::SRC_BCLK : pick_edge = edges[1];
         default                   : pick_edge = edges[2];
      endcase
   endfunction : pick_edge

   // ----------------------------------------
   // pin synchronisers and edge detect
   // ----------------------------------------
   logic [2:0] pin_meta;
   logic [2:0] pin_sync;
   logic [2:0] pin_last;
   logic [2:0] pin_edge;

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pin_meta <= 3'h0;
         pin_sync <= 3'h0;
         pin_last <= 3'h0;
      end else begin
         pin_meta <= {i_aux_pin_two, i_bclk, i_mclk};
         pin_sync <= pin_meta;
         pin_last <= pin_sync;
      end
   end

   // both edges count, so a source period gives two steps
   assign pin_edge = pin_sync ^ pin_last;

   // ----------------------------------------
   // clock source register
   // ----------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n)
         o_clock_source_select <= audio_clock_pkg::CLOCK_SOURCE_SELECT_RESET;
      else if (i_src_sel_wr)
         o_clock_source_select <= i_src_sel_data; // RL4 RL8
   end

   // ----------------------------------------
   // settings in force
   // ----------------------------------------
   // copies follow the inputs only while the path is off, so a change
   // never cuts a tick period short
   logic [1:0]  div_src;
   logic [1:0]  loop_src;
   logic        pll_on;
   logic        mux_sel;
   logic [4:0]  q;
   logic [3:0]  p;
   logic [4:0]  r;
   logic [5:0]  j;
   logic [13:0] d;
   logic [3:0]  m;
   logic [4:0]  n;
   logic [3:0]  ratio;
   logic        dbl;

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         div_src  <= 2'h0;
         loop_src <= 2'h0;
         pll_on   <= 1'b0;
         mux_sel  <= 1'b0;
         q        <= audio_clock_pkg::Q_MIN;
         p        <= 4'h1;
         r        <= 5'h01;
         j        <= 6'h01;
         d        <= 14'h0000;
         m        <= 4'h1;
         n        <= audio_clock_pkg::N_MIN;
         ratio    <= 4'h0;
         dbl      <= 1'b0;
      end else if (!i_clk_path_en) begin // RL17
         div_src  <= o_clock_source_select[audio_clock_pkg::DIV_SRC_LSB +: 2];
         loop_src <= o_clock_source_select[audio_clock_pkg::LOOP_SRC_LSB +: 2];
         pll_on   <= i_pll_en;
         mux_sel  <= i_clockout_source_select;
         q        <= i_q;
         p        <= i_p;
         r        <= i_r;
         j        <= i_j;
         d        <= i_d;
         m        <= i_m;
         n        <= i_n;
         ratio    <= i_dac_rate_ratio;
         dbl      <= i_double_rate;
      end
   end

   // ----------------------------------------
   // setting checks
   // ----------------------------------------
   logic loop_bad;
   logic div_bad;
   logic out_bad;
   logic cfg_bad;

   assign loop_bad = (j == 6'h00) || (d > audio_clock_pkg::FRAC_MAX) // RL7 RL16
                   || (p == 4'h0) || (p > audio_clock_pkg::P_MAX)
                   || (r == 5'h00) || (r > audio_clock_pkg::R_MAX);   // RL6
   assign div_bad  = (q < audio_clock_pkg::Q_MIN) || (q > audio_clock_pkg::Q_MAX) // RL3
                   || (q[0] && ratio[0])                                         // RL5
                   || (ratio > audio_clock_pkg::RATIO_CODE_MAX);
   assign out_bad  = !(m == 4'h1 || m == 4'h2 || m == 4'h4 || m == 4'h8)        // RL12
                   || (n < audio_clock_pkg::N_MIN) || (n > audio_clock_pkg::N_MAX);
   assign cfg_bad  = (pll_on ? loop_bad : div_bad) || (mux_sel ? out_bad
                   : (pll_on && out_bad));

   logic path_on;
   logic conv_on;

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         path_on     <= 1'b0;
         conv_on     <= 1'b0;
         o_cfg_error <= 1'b0;
      end else begin
         path_on     <= i_clk_path_en && !cfg_bad; // RL17
         conv_on     <= i_converter_pwr;
         o_cfg_error <= cfg_bad;                   // RL16
      end
   end

   // ----------------------------------------
   // master clock accumulator
   // ----------------------------------------
   logic [W-1:0] k_scaled;
   logic [W-1:0] kr;
   logic [W-1:0] m_inc;
   logic [W-1:0] m_thr;
   logic         m_edge;
   logic [W:0]   next_master;
   logic [W-1:0] master_acc;
   logic         master_run;

   assign k_scaled    = W'(j) * audio_clock_pkg::FRAC_SCALE + W'(d); // RL7
   assign kr          = k_scaled * W'(r);
   // loop: K*R/(16*P) ticks per source edge, divider: one tick per Q edges
   assign m_inc       = pll_on ? kr : W'(1);                               // RL2
   assign m_thr       = pll_on ? audio_clock_pkg::LOOP_EDGE_DIV * W'(p)
                                 * audio_clock_pkg::FRAC_SCALE             // RL6
                               : W'(q);                                    // RL3
   assign m_edge      = pick_edge(pll_on ? loop_src : div_src, pin_edge); // RL4 RL8
   assign master_run  = path_on && conv_on;
   assign next_master = nco_step(master_acc, m_inc, m_thr, m_edge);

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         master_acc    <= '0;
         o_master_tick <= 1'b0;
      end else if (!master_run) begin // RL17
         master_acc    <= '0;
         o_master_tick <= 1'b0;
      end else begin
         master_acc    <= next_master[W-1:0];
         o_master_tick <= next_master[W]; // RL1
      end
   end

   // ----------------------------------------
   // reference rate and sample rate
   // ----------------------------------------
   logic [7:0]  fs_cnt;
   logic [10:0] smp_cnt;
   logic [10:0] smp_period;

   // ratio code c means (c+2)/2, so 128*(c+2) master ticks, half in double rate
   assign smp_period = (audio_clock_pkg::TICKS_PER_HALF_STEP * (11'(ratio) + 11'h002))
                       >> dbl;

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         fs_cnt       <= 8'h00;
         o_fsref_tick <= 1'b0;
      end else if (!master_run) begin
         fs_cnt       <= 8'h00;
         o_fsref_tick <= 1'b0;
      end else begin
         o_fsref_tick <= o_master_tick && fs_cnt == audio_clock_pkg::MASTER_PER_FSREF_M1;
         if (o_master_tick)
            fs_cnt <= fs_cnt + 8'h01; // RL1
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         smp_cnt           <= 11'h000;
         o_dac_sample_tick <= 1'b0;
      end else if (!master_run) begin
         smp_cnt           <= 11'h000;
         o_dac_sample_tick <= 1'b0;
      end else begin
         o_dac_sample_tick <= o_master_tick && smp_cnt == smp_period - 11'h001; // RL15
         if (o_master_tick)
            smp_cnt <= (smp_cnt == smp_period - 11'h001) ? 11'h000 : smp_cnt + 11'h001;
      end
   end

   // ----------------------------------------
   // aux pin one clock output
   // ----------------------------------------
   // two toggles per output period; not gated by converter power
   logic [W-1:0] mn;
   logic [W-1:0] a_inc;
   logic [W-1:0] a_thr;
   logic         a_edge;
   logic         aux_run;
   logic [W:0]   next_aux;
   logic [W-1:0] aux_acc;

   assign mn       = W'(m) * W'(n);
   assign a_inc    = mux_sel ? audio_clock_pkg::AUX_EDGE_MUL                // RL12
                             : audio_clock_pkg::AUX_EDGE_MUL * kr;          // RL11
   assign a_thr    = mux_sel ? mn : mn * W'(p) * audio_clock_pkg::FRAC_SCALE;
   assign a_edge   = pick_edge(mux_sel ? div_src : loop_src, pin_edge);
   assign aux_run  = path_on && (mux_sel || pll_on); // RL13
   assign next_aux = nco_step(aux_acc, a_inc, a_thr, a_edge);

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         aux_acc       <= '0;
         o_aux_pin_one <= 1'b0;
      end else if (!aux_run) begin
         aux_acc       <= '0;
         o_aux_pin_one <= 1'b0;
      end else begin
         aux_acc       <= next_aux[W-1:0];
         o_aux_pin_one <= o_aux_pin_one ^ next_aux[W]; // RL11 RL12
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_arst_n);

   src_reg_write_a : assert property ( // RL4
      i_src_sel_wr |=> o_clock_source_select == $past(i_src_sel_data))
      else $error("clock source register did not take the write");

   frac_invalid_a : assert property ( // RL16
      pll_on && d > audio_clock_pkg::FRAC_MAX |=> o_cfg_error && !path_on)
      else $error("fraction above 9999 not flagged");

   q_range_a : assert property ( // RL3
      !pll_on && (q < audio_clock_pkg::Q_MIN || q > audio_clock_pkg::Q_MAX)
      |=> o_cfg_error ##1 !o_master_tick)
      else $error("quotient out of range not blocked");

   div_count_a : assert property ( // RL3
      master_run && !pll_on |-> master_acc < W'(q))
      else $error("divider count passed the quotient");

   path_off_clear_a : assert property ( // RL17
      !i_clk_path_en |=> ##1 master_acc == '0 && !o_master_tick && !o_aux_pin_one)
      else $error("clock path still running while disabled");

   settings_hold_a : assert property ( // RL17
      path_on && $stable(path_on) |-> $stable(q) && $stable(j) && $stable(d))
      else $error("settings moved while the path ran");

   fsref_period_a : assert property ( // RL1
      o_fsref_tick |-> $past(fs_cnt) == audio_clock_pkg::MASTER_PER_FSREF_M1
                       && $past(o_master_tick))
      else $error("reference tick not on the 256th master tick");

   sample_period_a : assert property ( // RL15
      o_dac_sample_tick |-> $past(smp_cnt) == $past(smp_period) - 11'h001)
      else $error("sample tick off its period");

   conv_gate_a : assert property ( // RL13
      !conv_on |=> !o_master_tick)
      else $error("master tick with converters down");

   aux_idle_a : assert property ( // RL11
      !mux_sel && !pll_on |=> ##1 !o_aux_pin_one)
      else $error("aux output running with no source");

   master_cov_c : cover property (o_master_tick && pll_on);
   fsref_cov_c  : cover property (o_fsref_tick && !pll_on);
   aux_cov_c    : cover property (!conv_on && $changed(o_aux_pin_one));
   error_cov_c  : cover property ($rose(o_cfg_error));

endmodule : audio_clock_generation
`default_nettype wire

// [rtl/audio_clock_pkg.sv]
// constants and types shared by the audio clock generation block
//
// What this block does
// RL1: The block makes a converter master clock tick train at 256 times the reference rate.
// RL2: The master clock pin goes through the integer divider or the loop, bit clock or aux pin two may stand in.
// RL3: With the loop off the reference rate is the divider source over 128 times Q, Q from 2 to 17.
// RL4: Bits 7 and 6 of the clock source register pick master clock, bit clock or aux pin two for the divider.
// RL5: Software avoids odd Q with a half-step rate ratio and keeps the reference rate near 39 to 53 kHz.
// RL6: With the loop on the reference rate is source times K times R over 2048 times P, P 1..8, R 1..16.
// RL7: The multiplier K is an integer part 1..63 plus a fraction of four decimal digits 0000..9999.
// RL8: Bits 5 and 4 of the clock source register pick the loop source.
// RL9: With no fraction, software keeps source over P at 2..20 MHz, loop output at 80..110 MHz, J at 4..55.
// RL10: With a fraction, software keeps source over P at 10..20 MHz, output at 80..110 MHz, J 4..11, R one.
// RL11: With output select zero and the loop on, aux pin one carries source times 2KR over M times N times P.
// RL12: With output select one, aux pin one carries the divider source times 2 over M times N, M 1/2/4/8, N 2..17.
// RL13: With the converters powered down the loop still drives aux pin one from aux pin two.
// RL14: The system supplies a master clock and sets up the clocks whenever a converter runs.
// RL15: The sample rate is the reference rate, or twice it, over a ratio from 1 to 6 in half steps; codes above 10 are flagged only with the loop off.
// RL16: The fraction is binary ten-thousandths and values above 9999 are an invalid setting.
// RL17: New divider or loop settings take hold only when the clock path is enabled again.
`default_nettype none
package audio_clock_pkg;
   localparam logic [7:0]  CLOCK_SOURCE_SELECT_OFFSET = 8'h66;
   localparam logic [7:0]  CLOCK_SOURCE_SELECT_RESET  = 8'h00;
   localparam int          DIV_SRC_LSB                = 6;
   localparam int          LOOP_SRC_LSB               = 4;
   localparam int          ACC_W                      = 28;
   localparam logic [27:0] FRAC_SCALE                 = 28'h0002710; // 10000
   localparam logic [13:0] FRAC_MAX                   = 14'h270f;    // 9999
   localparam logic [27:0] LOOP_EDGE_DIV              = 28'h0000010; // 2048/256*2 edges
   localparam logic [4:0]  Q_MIN                      = 5'h02;
   localparam logic [4:0]  Q_MAX                      = 5'h11;
   localparam logic [3:0]  P_MAX                      = 4'h8;
   localparam logic [4:0]  R_MAX                      = 5'h10;
   localparam logic [4:0]  N_MIN                      = 5'h02;
   localparam logic [4:0]  N_MAX                      = 5'h11;
   localparam logic [3:0]  RATIO_CODE_MAX             = 4'ha;        // ratio 6
   localparam logic [7:0]  MASTER_PER_FSREF_M1        = 8'hff;       // 256 ticks
   localparam logic [10:0] TICKS_PER_HALF_STEP        = 11'h080;     // 128
   localparam logic [27:0] AUX_EDGE_MUL               = 28'h0000002;

   typedef enum logic [1:0] {
      SRC_MCLK    = 2'h0,
      SRC_BCLK    = 2'h1,
      SRC_AUX_TWO = 2'h2
   } clk_src_t;
endpackage : audio_clock_pkg
`default_nettype wire

// [tb/audio_clock_generation_test.sv]
// self-checking bench for the audio clock generation block
`timescale 1ns/10ps
`default_nettype none
module audio_clock_generation_test;
   typedef struct {int q, p, r, j, d, m, n, rc, pll, mux, dbl;} cfg_t;
   logic        clk = 1'b0, arst_n = 1'b0, wr = 1'b0, en = 1'b0, pwr = 1'b1;
   logic        pll = 1'b0, mux = 1'b0, dbl = 1'b0;
   logic [7:0]  sel_data = 8'h00, hm = 8'h02, hb = 8'h03, ha = 8'h05;
   logic [4:0]  q = 5'h02, r = 5'h01, n = 5'h02;
   logic [3:0]  p = 4'h1, m = 4'h1, rc = 4'h0;
   logic [5:0]  j = 6'h01;
   logic [13:0] d = 14'h0000;
   wire logic   mclk, bclk, aux2, mt, ft, st, aux1, err;
   wire logic [7:0] reg_q;
   int          n_mismatch = 0, total_checks = 0;
   int          hs[3];
   int          exp_q[$];
   cfg_t        c;

   clock_source_model src_u (.i_ref_clk(clk), .i_half_mclk(hm), .i_half_bclk(hb),
      .i_half_aux(ha), .o_mclk(mclk), .o_bclk(bclk), .o_aux_pin_two(aux2));
   audio_clock_generation dut_u (.i_ref_clk(clk), .i_arst_n(arst_n), .i_mclk(mclk),
      .i_bclk(bclk), .i_aux_pin_two(aux2), .i_src_sel_wr(wr), .i_src_sel_data(sel_data),
      .i_clk_path_en(en), .i_converter_pwr(pwr), .i_pll_en(pll),
      .i_clockout_source_select(mux), .i_q(q), .i_p(p), .i_r(r), .i_j(j), .i_d(d),
      .i_m(m), .i_n(n), .i_dac_rate_ratio(rc), .i_double_rate(dbl),
      .o_clock_source_select(reg_q), .o_master_tick(mt), .o_fsref_tick(ft),
      .o_dac_sample_tick(st), .o_aux_pin_one(aux1), .o_cfg_error(err));

   always #20 clk = ~clk;

   // ---------------------------------------------------------------
   // compares and model
   // ---------------------------------------------------------------
   task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: register %h expected %h", $time, got, exp);
      end
   endtask : check_reg

   task automatic check_flag(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: config flag %b expected %b", $time, got, exp);
      end
   endtask : check_flag

   task automatic check_span(input int got, input int exp);
      total_checks++;
      if (got != exp) begin
         n_mismatch++;
         $display("mismatch at %0t: span %0d cycles expected %0d", $time, got, exp);
      end
   endtask : check_span

   function automatic logic bad(input cfg_t k);
      logic b;
      if (k.pll != 0) b = k.j < 1 || k.d > 9999 || k.p < 1 || k.p > 8 || k.r < 1 || k.r > 16;
      else b = k.q < 2 || k.q > 17 || (k.q % 2 == 1 && k.rc % 2 == 1) || k.rc > 10;
      if (k.mux != 0 || k.pll != 0) b = b || !(k.m inside {1, 2, 4, 8}) || k.n < 2 || k.n > 17;
      return b;
   endfunction : bad

   task automatic tally_and_finish();
      if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish

   // ---------------------------------------------------------------
   // drivers
   // ---------------------------------------------------------------
   task automatic wr_reg(input logic [7:0] v);
      @(posedge clk);
      #1;
      wr = 1'b1;
      sel_data = v;
      @(posedge clk);
      #1;
      wr = 1'b0;
      check_reg(reg_q, v);
   endtask : wr_reg

   // settings only load while the path is off, so drop it around every change
   task automatic load(input cfg_t k);
      @(posedge clk);
      #1;
      en = 1'b0;
      {q, p, r, j, d} = {5'(k.q), 4'(k.p), 5'(k.r), 6'(k.j), 14'(k.d)};
      {m, n, rc, pll, mux, dbl} = {4'(k.m), 5'(k.n), 4'(k.rc), 1'(k.pll), 1'(k.mux), 1'(k.dbl)};
      repeat (2) @(posedge clk);
      #1;
      en = 1'b1;
   endtask : load

   // sel 0 master, 1 fsref, 2 sample, 3 aux rising; first event is warm-up
   task automatic expect_span(input int sel, input int nt, input int exp);
      int   seen, t0, got, lim;
      logic v, pv;
      seen = -1;
      got = -1;
      t0 = 0;
      pv = 1'b1;
      lim = (exp < 0) ? 2000 : 3 * exp + 400;
      for (int k = 0; k < lim && seen < nt; k++) begin
         @(posedge clk);
         #1;
         v = (sel == 0) ? mt : (sel == 1) ? ft : (sel == 2) ? st : aux1;
         if (v === 1'b1 && (sel != 3 || pv === 1'b0)) begin
            seen++;
            if (seen == 0) t0 = k;
            got = k - t0;
         end
         pv = v;
      end
      if (seen < nt) got = -1;
      check_span(got, exp);
   endtask : expect_span

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(32'h09d82be4));
      hs = '{2, 3, 5};
      repeat (5) @(posedge clk);
      #1;
      arst_n = 1'b1;
      check_reg(reg_q, 8'h00);
      for (int k = 0; k < 4; k++) wr_reg(8'($urandom()));
      for (int s = 0; s < 3; s++) begin
         wr_reg(8'(s << 6));
         c = '{2, 1, 1, 1, 0, 1, 2, 0, 0, 0, 0};
         c.q = $urandom_range(2, 17);
         load(c);
         expect_span(0, 1, c.q * hs[s]);
      end
      for (int s = 0; s < 3; s++) begin
         wr_reg(8'(s << 4));
         c = '{2, 1, 1, 1, 0, 1, 2, 0, 1, 0, 0};
         c.p = $urandom_range(1, 8);
         c.r = $urandom_range(1, 2);
         c.j = $urandom_range(4, (16 * c.p / c.r > 55) ? 55 : 16 * c.p / c.r);
         load(c);
         expect_span(0, c.j * c.r, 16 * c.p * hs[s]);
      end
      wr_reg(8'h00);
      c = '{2, 1, 1, 8, 5000, 1, 2, 0, 1, 0, 0};
      load(c);
      expect_span(0, 17, 64);
      for (int s = 0; s < 3; s++) begin
         wr_reg(8'(s << 6));
         c = '{2, 1, 1, 1, 0, 1, 2, 0, s % 2, 1, 0};
         c.m = 1 << $urandom_range(0, 3);
         c.n = $urandom_range(2, 17);
         load(c);
         expect_span(3, 1, c.m * c.n * hs[s]);
      end
      wr_reg(8'h20);
      pwr = 1'b0;
      c = '{2, 2, 1, 1, 0, 2, 3, 0, 1, 0, 0};
      load(c);
      expect_span(3, 1, 12 * hs[2]);
      expect_span(0, 0, -1);
      pwr = 1'b1;
      wr_reg(8'h00);
      c = '{2, 1, 1, 16, 0, 1, 2, 0, 1, 0, 0};
      load(c);
      expect_span(1, 1, 512);
      for (int k = 0; k <= 10; k++) exp_q.push_back(256 * (k + 2) / (1 + k % 2));
      for (int k = 0; k <= 10; k++) begin
         c.rc = k;
         c.dbl = k % 2;
         load(c);
         expect_span(2, 1, exp_q.pop_front());
      end
      c = '{4, 1, 1, 1, 0, 1, 2, 0, 0, 0, 0};
      load(c);
      q = 5'h08;
      expect_span(0, 1, 8);
      c.q = 8;
      load(c);
      expect_span(0, 1, 16);
      // mid-run reset: register and working set fall back while the path stays enabled
      arst_n = 1'b0;
      @(posedge clk);
      #1;
      arst_n = 1'b1;
      check_reg(reg_q, 8'h00);
      check_flag(err, 1'b0);
      expect_span(0, 1, 4);
      for (int k = 0; k < 60; k++) begin
         c = '{$urandom_range(1, 18), $urandom_range(0, 9), $urandom_range(0, 17),
               $urandom_range(0, 63), ($urandom_range(0, 7) == 0) ? 10000 : $urandom_range(0, 9999),
               $urandom_range(0, 9), $urandom_range(1, 18), $urandom_range(0, 11),
               $urandom_range(0, 1), $urandom_range(0, 1), 0};
         load(c);
         @(posedge clk);
         #1;
         check_flag(err, bad(c));
      end
      tally_and_finish();
   end

   initial begin
      #3000000;
      n_mismatch++;
      tally_and_finish();
   end
endmodule : audio_clock_generation_test
`default_nettype wire

// [tb/clock_source_model.sv]
// partner model: external master clock, bit clock and aux pin two sources
`timescale 1ns/10ps
`default_nettype none
module clock_source_model (
   input  wire logic       i_ref_clk,
   input  wire logic [7:0] i_half_mclk,
   input  wire logic [7:0] i_half_bclk,
   input  wire logic [7:0] i_half_aux,
   output logic            o_mclk,
   output logic            o_bclk,
   output logic            o_aux_pin_two
);
   int         cm  = 0;
   int         cb  = 0;
   int         ca  = 0;
   logic [2:0] lvl = 3'h0;

   // one process owns the levels, the ports only follow them
   assign {o_aux_pin_two, o_bclk, o_mclk} = lvl;

   // half periods stay at two ref cycles or more, else the synchroniser drops levels
   always @(posedge i_ref_clk) begin
      #1;
      cm++;
      cb++;
      ca++;
      if (cm >= i_half_mclk) begin
         lvl[0] = ~lvl[0];
         cm = 0;
      end
      if (cb >= i_half_bclk) begin
         lvl[1] = ~lvl[1];
         cb = 0;
      end
      if (ca >= i_half_aux) begin
         lvl[2] = ~lvl[2];
         ca = 0;
      end
   end
endmodule : clock_source_model
`default_nettype wire
